// ==== dv/i2c_host_model.sv ====
// Two-wire bus host model driving clock and data towards the expander
`timescale 1ns/10ps

module i2c_host_model (
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe
);
	// Odd quarter bit keeps the bus clock out of step with i_clk
	localparam time QTR = 812ns;

	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end

	// Data released before clock rises, so this also forms a repeated start
	task automatic start();
		o_sda_oe = 1'b0;
		#QTR;
		o_scl = 1'b1;
		#QTR;
		o_sda_oe = 1'b1;
		#QTR;
		o_scl = 1'b0;
		#QTR;
	endtask

	task automatic stop();
		o_sda_oe = 1'b1;
		#QTR;
		o_scl = 1'b1;
		#QTR;
		o_sda_oe = 1'b0;
		#QTR;
	endtask

	// Clock high and low both last two quarters
	task automatic bit_xfer(input logic b, output logic r);
		o_sda_oe = ~b;
		#QTR;
		o_scl = 1'b1;
		#QTR;
		r = i_sda;
		#QTR;
		o_scl = 1'b0;
		#QTR;
	endtask

	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(b[i], r);
		end
		bit_xfer(1'b1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, b[i]);
		end
		bit_xfer(last, r);
	endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the sixteen-line I/O expander
`timescale 1ns/10ps
`include "ioexp_map.svh"

module tb;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_reset_n = 1'b1;
	logic [1:0] asel = 2'h0;
	logic [15:0] ext = 16'h0000;
	logic scl;
	logic host_oe;
	logic sda;
	logic sda_oe;
	logic int_oe;
	logic sda_out;
	logic int_out;
	logic [15:0] port_out;
	logic [15:0] port_oe;
	logic [15:0] lvl;
	logic [15:0] rd;
	logic ack;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;

	always #25 i_clk = ~i_clk;
	// Pull-up on the data wire; driven lines follow the device
	assign sda = ~host_oe & (~sda_oe | sda_out);
	assign lvl = (port_oe & port_out) | (~port_oe & ext);

	io_expander dut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_reset_n(i_reset_n),
		.i_addr_select_low(asel[0]),
		.i_addr_select_high(asel[1]),
		.i_scl(scl),
		.i_sda_in(sda),
		.o_sda_out(sda_out),
		.o_sda_oe(sda_oe),
		.i_port_in(lvl),
		.o_port_out(port_out),
		.o_port_oe(port_oe),
		.o_int_out(int_out),
		.o_int_oe(int_oe)
	);

	i2c_host_model host (
		.i_sda(sda),
		.o_scl(scl),
		.o_sda_oe(host_oe)
	);

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic set_ext(input logic [15:0] v);
		@(posedge i_clk);
		ext <= v;
		wait_clk(10);
	endtask

	task automatic probe(input logic [1:0] a, input logic exp);
		host.start();
		host.wbyte({`IOX_ADDR_BASE, a, 1'b0}, ack);
		host.stop();
		check("addr ack", {15'h0000, ack}, {15'h0000, exp});
		wait_clk(8);
	endtask

	task automatic wr16(input logic [1:0] r, input logic [15:0] v);
		host.start();
		host.wbyte({`IOX_ADDR_BASE, asel, 1'b0}, ack);
		host.wbyte({5'h00, r, 1'b0}, ack);
		host.wbyte(v[7:0], ack);
		host.wbyte(v[15:8], ack);
		host.stop();
		wait_clk(8);
	endtask

	task automatic rd16(input logic [1:0] r, output logic [15:0] v);
		host.start();
		host.wbyte({`IOX_ADDR_BASE, asel, 1'b0}, ack);
		host.wbyte({5'h00, r, 1'b0}, ack);
		host.start();
		host.wbyte({`IOX_ADDR_BASE, asel, 1'b1}, ack);
		host.rbyte(1'b0, v[7:0]);
		host.rbyte(1'b1, v[15:8]);
		host.stop();
		wait_clk(8);
	endtask

	// Lines 4 to 11 are outputs at 16'ha355, polarity flips bank 0
	function automatic logic [15:0] exp_in(input logic [15:0] e);
		return ((16'h0ff0 & 16'ha355) | (16'hf00f & e)) ^ 16'h00ff;
	endfunction

	task automatic done_test(input string name);
		$display("test %s done", name);
	endtask

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 80000) begin
			failures++;
			summarize();
		end
	end

	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		wait_clk(8);
		check("oe reset", port_oe, 16'h0000);
		check("out reset", port_out, `IOX_OUT_RST);
		check("int reset", {15'h0000, int_oe}, 16'h0000);
		done_test("reset");
		for (int a = 0; a < 4; a++) begin
			@(posedge i_clk);
			asel <= a[1:0];
			wait_clk(8);
			probe(a[1:0], 1'b1);
			probe(a[1:0] ^ 2'h1, 1'b0);
		end
		done_test("address");
		wr16(`IOX_REG_OUT, 16'ha355);
		check("out", port_out, 16'ha355);
		wr16(`IOX_REG_CFG, 16'hf00f);
		check("oe", port_oe, 16'h0ff0);
		wr16(`IOX_REG_POL, 16'h00ff);
		// Input bytes take no write; the reads below show nothing moved
		wr16(`IOX_REG_IN, 16'h5a5a);
		rd16(`IOX_REG_CFG, rd);
		check("cfg rd", rd, 16'hf00f);
		rd16(`IOX_REG_OUT, rd);
		check("out rd", rd, 16'ha355);
		rd16(`IOX_REG_POL, rd);
		check("pol rd", rd, 16'h00ff);
		check("out held", port_out, 16'ha355);
		done_test("registers");
		set_ext(16'h6c3a);
		rd16(`IOX_REG_IN, rd);
		check("in rd", rd, exp_in(16'h6c3a));
		check("int idle", {15'h0000, int_oe}, 16'h0000);
		set_ext(16'h6c3b);
		check("int bank0", {15'h0000, int_oe}, 16'h0001);
		check("int low", {15'h0000, int_out}, 16'h0000);
		set_ext(16'h6c3a);
		check("int match", {15'h0000, int_oe}, 16'h0000);
		set_ext(16'h7c3a);
		check("int bank1", {15'h0000, int_oe}, 16'h0001);
		rd16(`IOX_REG_IN, rd);
		check("in rd2", rd, exp_in(16'h7c3a));
		check("int read", {15'h0000, int_oe}, 16'h0000);
		done_test("input and interrupt");
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		wait_clk(4);
		check("oe pin rst", port_oe, 16'h0000);
		check("out pin rst", port_out, `IOX_OUT_RST);
		@(posedge i_clk);
		i_reset_n <= 1'b1;
		wait_clk(8);
		rd16(`IOX_REG_POL, rd);
		check("pol pin rst", rd, `IOX_POL_RST);
		done_test("reset pin");
		summarize();
	end
endmodule

// ==== hw/io_expander.sv ====
// Sixteen-line I/O expander core: bus slave, port registers, interrupt
//
// Function
// [RULE_01] Sixteen lines in two eight-bit banks
// [RULE_02] All lines are inputs after power-up
// [RULE_03] Direction bit decides drive or release
// [RULE_04] Input and output registers hold line values
// [RULE_05] Polarity bit inverts input register value
// [RULE_06] Every register reads back its contents
// [RULE_07] Power-on loads defaults, idles bus machine
// [RULE_08] Reset pin low does the same reset
// [RULE_09] Interrupt low while inputs differ from register
// [RULE_10] Two pins select one of four addresses
// [RULE_11] Works with bus clock up to fast-mode
// [RULE_12] Outputs hold last written value
// [RULE_13] Command byte picks register, data follows
// [RULE_14] Interrupt releases on match or input read
`timescale 1ns/10ps
`include "ioexp_map.svh"

module io_expander
	import ioexp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_reset_n,
	input wire logic i_addr_select_low,
	input wire logic i_addr_select_high,
	input wire logic i_scl,
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic [15:0] i_port_in,
	output logic [15:0] o_port_out,
	output logic [15:0] o_port_oe,
	output logic o_int_out,
	output logic o_int_oe
);

	localparam core_state_t CORE_RST = '{
		ph: PH_IDLE,
		out_r: `IOX_OUT_RST,
		pol_r: `IOX_POL_RST,
		cfg_r: `IOX_CFG_RST,
		clr: 1'b1,
		rstn_m: 1'b1,
		rstn_s: 1'b1,
		scl_m: 1'b1,
		scl_s: 1'b1,
		scl_p: 1'b1,
		sda_m: 1'b1,
		sda_s: 1'b1,
		sda_p: 1'b1,
		default: '0
	};

	function automatic logic [7:0] pick_byte(input logic [15:0] v,
		input logic bank);
		return bank ? v[15:8] : v[7:0];
	endfunction

	function automatic logic [15:0] put_byte(input logic [15:0] v,
		input logic bank, input logic [7:0] b);
		return bank ? {b, v[7:0]} : {v[15:8], b};
	endfunction

	function automatic logic [7:0] reg_byte(input logic [2:0] p,
		input logic [15:0] inv, input logic [15:0] o,
		input logic [15:0] pl, input logic [15:0] c);
		logic [15:0] w;
		case (p[2:1])
			`IOX_REG_IN: w = inv;
			`IOX_REG_OUT: w = o;
			`IOX_REG_POL: w = pl;
			default: w = c;
		endcase
		return pick_byte(w, p[0]);
	endfunction

	core_state_t st_reg;
	core_state_t st_next;
	logic [7:0] link_byte;
	logic link_tgl;
	logic scl_rise;
	logic scl_fall;
	logic start_evt;
	logic stop_evt;
	logic byte_evt;
	logic soft_rst;
	logic rd_load;
	logic wr_evt;
	logic [15:0] pin_pol;
	logic [6:0] own_addr;
	logic [7:0] rd_byte;

	ioexp_link link_u (
		.i_scl(i_scl),
		.i_sda(i_sda_in),
		.i_clr(st_reg.clr),
		.o_rx_byte(link_byte),
		.o_rx_toggle(link_tgl)
	);

	assign scl_rise = st_reg.scl_s & ~st_reg.scl_p;
	assign scl_fall = ~st_reg.scl_s & st_reg.scl_p;
	assign start_evt = st_reg.scl_s & st_reg.scl_p & st_reg.sda_p
		& ~st_reg.sda_s;
	assign stop_evt = st_reg.scl_s & st_reg.scl_p & ~st_reg.sda_p
		& st_reg.sda_s;
	// Clearing the link drops its toggle; that echo is no byte
	assign byte_evt = (st_reg.tgl_s ^ st_reg.tgl_p) && !st_reg.clr;
	assign soft_rst = ~st_reg.rstn_s;
	assign pin_pol = st_reg.pin_s ^ st_reg.pol_r; // see [RULE_05]
	assign own_addr = {`IOX_ADDR_BASE, st_reg.asel_s}; // see [RULE_10]
	assign wr_evt = byte_evt && st_reg.ph == PH_WR;
	assign rd_load = scl_fall && !st_reg.ack_pend && st_reg.ph == PH_RD
		&& st_reg.bits == `IOX_BITS_LOAD && !start_evt && !stop_evt;
	assign rd_byte = reg_byte(st_reg.ptr, pin_pol, st_reg.out_r,
		st_reg.pol_r, st_reg.cfg_r); // see [RULE_06]

	always_comb begin
		st_next = st_reg;
		// Two stages on every pin; ample margin at fast-mode rates
		st_next.scl_m = i_scl; // see [RULE_11]
		st_next.scl_s = st_reg.scl_m;
		st_next.scl_p = st_reg.scl_s;
		st_next.sda_m = i_sda_in;
		st_next.sda_s = st_reg.sda_m;
		st_next.sda_p = st_reg.sda_s;
		st_next.rstn_m = i_reset_n;
		st_next.rstn_s = st_reg.rstn_m;
		st_next.tgl_m = link_tgl;
		st_next.tgl_s = st_reg.tgl_m;
		st_next.tgl_p = st_reg.tgl_s;
		st_next.asel_m = {i_addr_select_high, i_addr_select_low};
		st_next.asel_s = st_reg.asel_m;
		st_next.pin_m = i_port_in;
		st_next.pin_s = st_reg.pin_m;

		if (start_evt) begin
			st_next.ph = PH_ADDR;
			st_next.clr = 1'b1;
			st_next.ack_pend = 1'b0;
			st_next.acking = 1'b0;
			st_next.sda_oe = 1'b0;
			st_next.bits = `IOX_BITS_LOAD;
		end else if (stop_evt) begin
			st_next.ph = PH_IDLE;
			st_next.clr = 1'b1;
			st_next.ack_pend = 1'b0;
			st_next.acking = 1'b0;
			st_next.sda_oe = 1'b0;
		end else begin
			// Link counter held clear until the first low clock phase
			if (scl_fall && st_reg.ph != PH_IDLE) begin
				st_next.clr = 1'b0;
			end
			if (byte_evt) begin
				case (st_reg.ph)
					PH_ADDR: begin
						if (link_byte[7:1] == own_addr) begin // see [RULE_10]
							st_next.ack_pend = 1'b1;
							st_next.bits = `IOX_BITS_LOAD;
							st_next.ph = link_byte[0] ? PH_RD : PH_CMD;
						end else begin
							st_next.ph = PH_IDLE;
							st_next.clr = 1'b1;
						end
					end
					PH_CMD: begin
						st_next.ptr = link_byte[2:0]; // see [RULE_13]
						st_next.ack_pend = 1'b1;
						st_next.ph = PH_WR;
					end
					PH_WR: begin
						st_next.ack_pend = 1'b1;
						// Writes walk within a bank pair, input bytes ignored
						st_next.ptr = {st_reg.ptr[2:1], ~st_reg.ptr[0]}; // see [RULE_13]
						case (st_reg.ptr[2:1])
							`IOX_REG_OUT: st_next.out_r = put_byte(st_reg.out_r,
								st_reg.ptr[0], link_byte); // see [RULE_12]
							`IOX_REG_POL: st_next.pol_r = put_byte(st_reg.pol_r,
								st_reg.ptr[0], link_byte); // see [RULE_05]
							`IOX_REG_CFG: st_next.cfg_r = put_byte(st_reg.cfg_r,
								st_reg.ptr[0], link_byte); // see [RULE_03]
							default: st_next.ptr = st_next.ptr;
						endcase
					end
					default: st_next.ph = st_reg.ph;
				endcase
			end
			if (scl_fall) begin
				if (st_reg.acking) begin
					st_next.acking = 1'b0;
					st_next.sda_oe = 1'b0;
				end else if (st_reg.ack_pend) begin
					st_next.ack_pend = 1'b0;
					st_next.acking = 1'b1;
					st_next.sda_oe = 1'b1;
				end
				if (rd_load) begin
					st_next.sh = rd_byte; // see [RULE_06]
					st_next.sda_oe = ~rd_byte[7];
					st_next.bits = `IOX_BITS_FIRST;
					// Reading an input byte refreshes the stored compare value
					if (st_reg.ptr[2:1] == `IOX_REG_IN) begin
						st_next.inr = put_byte(st_reg.inr, st_reg.ptr[0],
							pick_byte(pin_pol, st_reg.ptr[0])); // see [RULE_14]
					end
				end else if (st_reg.ph == PH_RD
					&& st_reg.bits != `IOX_BITS_LOAD
					&& st_reg.bits < `IOX_BITS_LAST) begin
					st_next.sh = {st_reg.sh[6:0], 1'b0};
					st_next.sda_oe = ~st_reg.sh[6];
					st_next.bits = st_reg.bits + 4'h1;
				end else if (st_reg.ph == PH_RD
					&& st_reg.bits == `IOX_BITS_LAST) begin
					st_next.sda_oe = 1'b0;
					st_next.bits = `IOX_BITS_MACK;
				end
			end
			if (scl_rise && st_reg.ph == PH_RD
				&& st_reg.bits == `IOX_BITS_MACK) begin
				if (st_reg.sda_s) begin
					st_next.ph = PH_SKIP;
				end else begin
					st_next.bits = `IOX_BITS_LOAD;
					st_next.ptr = {st_reg.ptr[2:1], ~st_reg.ptr[0]}; // see [RULE_13]
				end
			end
		end

		// First cycle after reset seeds the compare value; no false alarm after the reset pin, but after i_rst the cleared pin syncs seed zero
		if (!st_reg.init) begin
			st_next.inr = pin_pol; // see [RULE_04]
			st_next.init = 1'b1;
		end
		st_next.int_oe = st_reg.init && (pin_pol != st_reg.inr); // see [RULE_09]

		// Reset pin: same defaults as power-on, pin syncs keep running
		if (soft_rst) begin // see [RULE_08]
			st_next.ph = PH_IDLE;
			st_next.ptr = `IOX_PTR_RST;
			st_next.out_r = `IOX_OUT_RST;
			st_next.pol_r = `IOX_POL_RST;
			st_next.cfg_r = `IOX_CFG_RST;
			st_next.inr = `IOX_INR_RST;
			st_next.bits = `IOX_BITS_LOAD;
			st_next.ack_pend = 1'b0;
			st_next.acking = 1'b0;
			st_next.sda_oe = 1'b0;
			st_next.clr = 1'b1;
			st_next.init = 1'b0;
			st_next.int_oe = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= CORE_RST; // see [RULE_07]
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = st_reg.sda_oe;
	assign o_port_out = st_reg.out_r; // see [RULE_04]
	assign o_port_oe = ~st_reg.cfg_r; // see [RULE_02]
	assign o_int_out = 1'b0;
	assign o_int_oe = st_reg.int_oe;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	dir_reset_a: assert property (disable iff (1'b0) // see [RULE_07]
		i_rst |=> (o_port_oe == ~`IOX_CFG_RST && st_reg.ph == PH_IDLE
			&& !o_sda_oe && !o_int_oe))
		else $error("port drives or bus busy after reset");

	pin_reset_a: assert property ( // see [RULE_08]
		soft_rst |=> (st_reg.cfg_r == `IOX_CFG_RST
			&& st_reg.out_r == `IOX_OUT_RST && st_reg.ph == PH_IDLE))
		else $error("reset pin did not restore defaults");

	dir_write_a: assert property ( // see [RULE_03]
		wr_evt && st_reg.ptr[2:1] == `IOX_REG_CFG && !soft_rst
			&& !start_evt && !stop_evt
		|=> pick_byte(~o_port_oe, $past(st_reg.ptr[0])) == $past(link_byte))
		else $error("direction write not seen on output enables");

	out_hold_a: assert property ( // see [RULE_12]
		!(wr_evt && st_reg.ptr[2:1] == `IOX_REG_OUT) && !soft_rst
		|=> $stable(o_port_out))
		else $error("output value changed without a write");

	in_sample_a: assert property ( // see [RULE_05]
		rd_load && st_reg.ptr[2:1] == `IOX_REG_IN && st_reg.init && !soft_rst
		|=> pick_byte(st_reg.inr, $past(st_reg.ptr[0]))
			== $past(pick_byte(pin_pol, st_reg.ptr[0])))
		else $error("input register not loaded with polarity level");

	read_data_a: assert property ( // see [RULE_06]
		rd_load && !soft_rst |=> st_reg.sh == $past(rd_byte)
			##1 (st_reg.sh == $past(st_reg.sh) || !$stable(st_reg.bits)))
		else $error("read shifter not loaded from selected register");

	int_set_a: assert property ( // see [RULE_09]
		st_reg.init && pin_pol != st_reg.inr && !soft_rst |=> o_int_oe)
		else $error("interrupt not driven on input mismatch");

	int_clear_a: assert property ( // see [RULE_14]
		pin_pol == st_reg.inr |=> !o_int_oe)
		else $error("interrupt held with inputs matching");

	addr_match_a: assert property ( // see [RULE_10]
		byte_evt && st_reg.ph == PH_ADDR && link_byte[7:1] != own_addr
			&& !start_evt && !stop_evt && !soft_rst
		|=> st_reg.ph == PH_IDLE && !st_reg.ack_pend ##1 !o_sda_oe)
		else $error("foreign address acknowledged");

	cmd_ptr_a: assert property ( // see [RULE_13]
		byte_evt && st_reg.ph == PH_CMD && !start_evt && !stop_evt
			&& !soft_rst
		|=> st_reg.ptr == $past(link_byte[2:0]) && st_reg.ack_pend
			&& st_reg.ph == PH_WR)
		else $error("command byte did not select register");

	wr_seen_c: cover property (wr_evt && st_reg.ptr[2:1] == `IOX_REG_OUT);
	rd_seen_c: cover property (rd_load ##[1:1000] st_reg.bits == `IOX_BITS_MACK);
	int_seen_c: cover property (!o_int_oe ##1 o_int_oe ##[1:1000] !o_int_oe);

endmodule

// ==== hw/ioexp_link.sv ====
// Serial link front end: shifts bytes in on the bus clock, hands them over
`timescale 1ns/10ps
`include "ioexp_map.svh"

module ioexp_link
	import ioexp_pkg::*;
(
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_clr,
	output logic [7:0] o_rx_byte,
	output logic o_rx_toggle
);

	localparam link_state_t LINK_RST = '{default: '0};

	link_state_t st_reg;
	link_state_t st_next;

	// Nine clocks per byte: eight data bits plus the acknowledge slot
	always_comb begin
		st_next = st_reg;
		st_next.shreg = {st_reg.shreg[6:0], i_sda};
		if (st_reg.cnt == `IOX_LINK_ACK_CNT) begin
			st_next.cnt = `IOX_BITS_LOAD;
		end else begin
			st_next.cnt = st_reg.cnt + 4'h1;
		end
		// Byte stays put for nine clocks, far longer than the sync delay
		if (st_reg.cnt == `IOX_LINK_LAST_CNT) begin
			st_next.rx = {st_reg.shreg[6:0], i_sda};
			st_next.tgl = ~st_reg.tgl;
		end
	end

	// Clear comes from the core while the bus clock is high and idle
	always_ff @(posedge i_scl or posedge i_clr) begin
		if (i_clr) begin
			st_reg <= LINK_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rx_byte = st_reg.rx;
	assign o_rx_toggle = st_reg.tgl;

endmodule

// ==== hw/ioexp_map.svh ====
// Register selectors, reset values and bit counts for the I/O expander
`ifndef IOEXP_MAP_SVH
`define IOEXP_MAP_SVH

`define IOX_REG_IN 2'h0
`define IOX_REG_OUT 2'h1
`define IOX_REG_POL 2'h2
`define IOX_REG_CFG 2'h3

`define IOX_OUT_RST 16'hffff
`define IOX_POL_RST 16'h0000
`define IOX_CFG_RST 16'hffff
`define IOX_INR_RST 16'h0000
`define IOX_PTR_RST 3'h0

`define IOX_ADDR_BASE 5'h14

`define IOX_BITS_LOAD 4'h0
`define IOX_BITS_FIRST 4'h1
`define IOX_BITS_LAST 4'h8
`define IOX_BITS_MACK 4'h9

`define IOX_LINK_LAST_CNT 4'h7
`define IOX_LINK_ACK_CNT 4'h8

`endif

// ==== hw/ioexp_pkg.sv ====
// Types shared by the I/O expander core and its serial link front end
package ioexp_pkg;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_CMD,
		PH_WR,
		PH_RD,
		PH_SKIP
	} phase_t;

	typedef struct packed {
		phase_t ph;
		logic [2:0] ptr;
		logic [15:0] out_r;
		logic [15:0] pol_r;
		logic [15:0] cfg_r;
		logic [15:0] inr;
		logic [7:0] sh;
		logic [3:0] bits;
		logic ack_pend;
		logic acking;
		logic sda_oe;
		logic clr;
		logic init;
		logic int_oe;
		logic scl_m;
		logic scl_s;
		logic scl_p;
		logic sda_m;
		logic sda_s;
		logic sda_p;
		logic rstn_m;
		logic rstn_s;
		logic tgl_m;
		logic tgl_s;
		logic tgl_p;
		logic [1:0] asel_m;
		logic [1:0] asel_s;
		logic [15:0] pin_m;
		logic [15:0] pin_s;
	} core_state_t;

	typedef struct packed {
		logic [7:0] shreg;
		logic [3:0] cnt;
		logic [7:0] rx;
		logic tgl;
	} link_state_t;

endpackage
